// >>> rtl/cpu_and_shift_bit_branch_exec.sv
// The register addresses and the AXI4-Lite register port were decided locally.
module cpu_and_shift_bit_branch_exec (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire exec_pkg::addr_t i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire exec_pkg::data_t i_wdata,
    input wire exec_pkg::strb_t i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output exec_pkg::resp_t o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire exec_pkg::addr_t i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output exec_pkg::data_t o_rdata,
    output exec_pkg::resp_t o_rresp
);
    import exec_pkg::*;

    // =========================================================================
    // State
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    resp_t bresp_q, rresp_q;
    data_t rdata_q, wdata_q;
    logic aw_got_q, w_got_q;
    addr_t awaddr_q;
    strb_t wstrb_q;
    logic [7:0] acc_q;
    logic [7:0] mem_q [FILE_DEPTH];
    logic c_q, z_q;
    pc_t pc_q;
    logic [6:0] fsel_q;
    instr_t instr_q;
    exec_state_e state_q;

    // =========================================================================
    // Register decode and byte-lane merge
    function automatic logic is_mapped(input addr_t a);
        return a inside {OFS_INSTR, OFS_ACC, OFS_STATUS, OFS_PC, OFS_FSEL, OFS_FDATA};
    endfunction

    function automatic data_t reg_read(input addr_t a);
        data_t v;
        v = 32'h0000_0000;
        unique case (a)
            OFS_INSTR: v = {18'h00000, instr_q};
            OFS_ACC: v = {24'h000000, acc_q};
            OFS_STATUS:
            begin
                v[STAT_C_BIT] = c_q;
                v[STAT_Z_BIT] = z_q;
                v[STAT_BUSY_BIT] = (state_q == EXEC_NOP);
            end
            OFS_PC: v = {17'h00000, pc_q};
            OFS_FSEL: v = {25'h0000000, fsel_q};
            OFS_FDATA: v = {24'h000000, mem_q[fsel_q]};
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // =========================================================================
    // Bus handshake
    wire aw_fire = i_awvalid & awready_q;
    wire w_fire = i_wvalid & wready_q;
    wire ar_fire = i_arvalid & arready_q;
    wire do_wr = aw_got_q & w_got_q & ~bvalid_q;
    wire aw_got_d = ~do_wr & (aw_got_q | aw_fire);
    wire w_got_d = ~do_wr & (w_got_q | w_fire);
    wire bvalid_d = do_wr | (bvalid_q & ~i_bready);
    wire rvalid_d = ar_fire | (rvalid_q & ~i_rready);
    wire wr_mapped = is_mapped(awaddr_q);
    data_t old_val;
    data_t wr_val;
    // A process, not an assign, so a change in any register the function reads is seen
    always_comb old_val = reg_read(awaddr_q);
    for (genvar g = 0; g < 4; g++)
    begin : g_lane
        assign wr_val[8*g +: 8] = wstrb_q[g] ? wdata_q[8*g +: 8] : old_val[8*g +: 8];
    end
    wire wr_instr = do_wr & (awaddr_q == OFS_INSTR);
    // A new instruction cannot start while the discarded slot is still running
    wire go = wr_instr & (state_q == EXEC_IDLE);
    wire refused = wr_instr & (state_q == EXEC_NOP);
    wire wr_acc = do_wr & (awaddr_q == OFS_ACC);
    wire wr_status = do_wr & (awaddr_q == OFS_STATUS);
    wire wr_pc = do_wr & (awaddr_q == OFS_PC);
    wire wr_fsel = do_wr & (awaddr_q == OFS_FSEL);
    wire wr_fdata = do_wr & (awaddr_q == OFS_FDATA);
    resp_t bresp_d;
    assign bresp_d = !wr_mapped ? RESP_DECERR : (refused ? RESP_SLVERR : RESP_OKAY);

    // =========================================================================
    // Instruction decode
    instr_t ins;
    op_s op;
    assign ins = wr_val[13:0];
    assign op.and_literal_op = (ins[13:8] == OPC_AND_LIT);
    assign op.and_file_op = (ins[13:8] == OPC_AND_FILE);
    assign op.arith_shift_right_op = (ins[13:8] == OPC_ASR);
    assign op.bit_clear_op = (ins[13:10] == OPC_BIT_CLEAR);
    assign op.bit_set_op = (ins[13:10] == OPC_BIT_SET);
    assign op.skip_if_bit_clear_op = (ins[13:10] == OPC_SKIP_CLEAR);
    assign op.literal_relative_branch_op = (ins[13:9] == OPC_LIT_BRANCH);
    assign op.accumulator_relative_branch_op = (ins == OPC_ACC_BRANCH);

    wire [6:0] f_addr = ins[6:0];
    wire [2:0] bit_idx = ins[9:7];
    wire dest_file = ins[7];
    wire [7:0] fval = mem_q[f_addr];
    wire [7:0] mask = 8'(8'h01 << bit_idx);
    wire [7:0] opnd = op.and_literal_op ? ins[7:0] : fval;
    // Shift keeps the sign bit and drops bit 0 into carry
    wire [7:0] shift_res = {fval[7], fval[7:1]};
    wire [7:0] alu_res = op.arith_shift_right_op ? shift_res : (acc_q & opnd);
    wire two_src = op.and_file_op | op.arith_shift_right_op;
    wire flag_z_upd = go & (op.and_literal_op | two_src);
    wire acc_we = go & (op.and_literal_op | (two_src & ~dest_file));
    wire file_we = go & ((two_src & dest_file) | op.bit_clear_op | op.bit_set_op);
    wire [7:0] file_wd = op.bit_clear_op ? (fval & ~mask)
        : (op.bit_set_op ? (fval | mask) : alu_res);
    wire skip = op.skip_if_bit_clear_op & ~fval[bit_idx];

    // Sums are cut to the PC width so targets wrap instead of overflowing
    wire pc_t pc_inc = pc_t'(pc_q + 15'h0001);
    wire pc_t bra_tgt = pc_t'(pc_inc + {{6{ins[8]}}, ins[8:0]});
    wire pc_t brw_tgt = pc_t'(pc_inc + {7'h00, acc_q});
    wire two_cycle = op.literal_relative_branch_op | op.accumulator_relative_branch_op | skip;
    pc_t pc_go;
    assign pc_go = op.literal_relative_branch_op ? bra_tgt
        : (op.accumulator_relative_branch_op ? brw_tgt
        : (skip ? pc_t'(pc_inc + 15'h0001) : pc_inc));

    // =========================================================================
    // Bus registers
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
        end
        else
        begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            awready_q <= ~aw_got_d & ~bvalid_d;
            wready_q <= ~w_got_d & ~bvalid_d;
            bvalid_q <= bvalid_d;
            if (do_wr)
                bresp_q <= bresp_d;
            arready_q <= ~rvalid_d;
            rvalid_q <= rvalid_d;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end
        else
        begin
            if (aw_fire)
                awaddr_q <= i_awaddr;
            if (w_fire)
                wdata_q <= i_wdata;
            if (w_fire)
                wstrb_q <= i_wstrb;
            if (ar_fire)
                rdata_q <= reg_read(i_araddr);
            if (ar_fire)
                rresp_q <= is_mapped(i_araddr) ? RESP_OKAY : RESP_DECERR;
        end
    end

    // =========================================================================
    // Core registers
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            acc_q <= ACC_RST;
            c_q <= 1'b0;
            z_q <= 1'b0;
            pc_q <= PC_RST;
            fsel_q <= 7'h00;
            instr_q <= INSTR_RST;
            state_q <= EXEC_IDLE;
        end
        else
        begin
            if (acc_we)
                acc_q <= alu_res;
            else if (wr_acc)
                acc_q <= wr_val[7:0];
            if (go & op.arith_shift_right_op)
                c_q <= fval[0];
            else if (wr_status)
                c_q <= wr_val[STAT_C_BIT];
            if (flag_z_upd)
                z_q <= (alu_res == 8'h00);
            else if (wr_status)
                z_q <= wr_val[STAT_Z_BIT];
            if (go)
                pc_q <= pc_go;
            else if (wr_pc)
                pc_q <= wr_val[14:0];
            if (wr_fsel)
                fsel_q <= wr_val[6:0];
            if (go)
                instr_q <= ins;
            state_q <= (go & two_cycle) ? EXEC_NOP : EXEC_IDLE;
        end
    end

    // Data file has no reset, as a real register file would not
    always_ff @(posedge i_clk)
    begin
        if (file_we)
            mem_q[f_addr] <= file_wd;
        else if (wr_fdata)
            mem_q[fsel_q] <= wr_val[7:0];
    end

    assign o_awready = awready_q;
    assign o_wready = wready_q;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_arready = arready_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;

    // =========================================================================
    // Assertions
    a_and_lit_acc: assert property (@(posedge i_clk) disable iff (i_rst)
        go && op.and_literal_op |=> acc_q == ($past(acc_q) & $past(ins[7:0])))
        else $error("and literal result wrong");
    a_and_file_dest: assert property (@(posedge i_clk) disable iff (i_rst)
        go && op.and_file_op && dest_file |=> mem_q[$past(f_addr)] == $past(acc_q & fval)
            && acc_q == $past(acc_q))
        else $error("and file destination wrong");
    a_shift_carry: assert property (@(posedge i_clk) disable iff (i_rst)
        go && op.arith_shift_right_op |=> c_q == $past(fval[0]))
        else $error("shift carry wrong");
    a_shift_msb: assert property (@(posedge i_clk) disable iff (i_rst)
        go && op.arith_shift_right_op && !dest_file |=> acc_q == {$past(fval[7]), $past(fval[7:1])})
        else $error("shift result wrong");
    a_bclr_flags: assert property (@(posedge i_clk) disable iff (i_rst)
        go && op.bit_clear_op |=> mem_q[$past(f_addr)] == ($past(fval) & ~$past(mask))
            && $stable(c_q) && $stable(z_q))
        else $error("bit clear wrong");
    a_bset_flags: assert property (@(posedge i_clk) disable iff (i_rst)
        go && op.bit_set_op |=> mem_q[$past(f_addr)] == ($past(fval) | $past(mask))
            && $stable(c_q) && $stable(z_q))
        else $error("bit set wrong");
    a_bra_target: assert property (@(posedge i_clk) disable iff (i_rst)
        go && op.literal_relative_branch_op |=> pc_q == $past(bra_tgt) && state_q == EXEC_NOP
            ##1 state_q == EXEC_IDLE)
        else $error("literal branch wrong");
    a_brw_target: assert property (@(posedge i_clk) disable iff (i_rst)
        go && op.accumulator_relative_branch_op
            |=> pc_q == pc_t'($past(pc_q) + 15'h0001 + {7'h00, $past(acc_q)}) && $stable(z_q))
        else $error("accumulator branch wrong");
    a_skip_taken: assert property (@(posedge i_clk) disable iff (i_rst)
        go && op.skip_if_bit_clear_op |=> (state_q == EXEC_NOP) == !$past(fval[bit_idx]))
        else $error("skip decision wrong");
    a_nop_refuse: assert property (@(posedge i_clk) disable iff (i_rst)
        state_q == EXEC_NOP && wr_instr |=> bresp_q == RESP_SLVERR && $stable(pc_q))
        else $error("instruction accepted in no-op cycle");
    a_zero_flag: assert property (@(posedge i_clk) disable iff (i_rst)
        flag_z_upd |=> z_q == ($past(alu_res) == 8'h00))
        else $error("zero flag wrong");
    a_single_cycle: assert property (@(posedge i_clk) disable iff (i_rst)
        go && !two_cycle |=> pc_q == pc_t'($past(pc_q) + 15'h0001) && state_q == EXEC_IDLE)
        else $error("single cycle step wrong");

endmodule // cpu_and_shift_bit_branch_exec

// >>> rtl/exec_pkg.sv
// Summary of operation
// - AND with literal: accumulator AND 8-bit literal into accumulator, zero flag only.
// - AND with file: accumulator AND file f; destination bit picks accumulator or f.
// - Arithmetic right shift: source 7:1 to result 6:0, source bit 0 to carry.
// - Arithmetic right shift keeps bit 7; destination bit picks accumulator or file.
// - Bit clear forces bit b of f to zero; other bits and flags untouched.
// - Bit set forces bit b of f to one; other bits and flags untouched.
// - Literal branch: PC becomes incremented PC plus signed 9-bit offset, two cycles.
// - Accumulator branch: PC becomes incremented PC plus unsigned accumulator, two cycles.
// - Skip if bit clear: bit zero discards next instruction, two cycles.
// - PC change or true test costs two cycles, the second one a no-operation.
package exec_pkg;

    // =========================================================================
    // Widths and types
    typedef logic [7:0] addr_t;
    typedef logic [31:0] data_t;
    typedef logic [3:0] strb_t;
    typedef logic [1:0] resp_t;
    typedef logic [14:0] pc_t;
    typedef logic [13:0] instr_t;

    localparam int FILE_DEPTH = 128;

    // =========================================================================
    // Register byte offsets
    localparam addr_t OFS_INSTR = 8'h00;
    localparam addr_t OFS_ACC = 8'h04;
    localparam addr_t OFS_STATUS = 8'h08;
    localparam addr_t OFS_PC = 8'h0C;
    localparam addr_t OFS_FSEL = 8'h10;
    localparam addr_t OFS_FDATA = 8'h14;

    // Status register fields
    localparam int STAT_C_BIT = 0;
    localparam int STAT_Z_BIT = 1;
    localparam int STAT_BUSY_BIT = 8;

    // Reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam pc_t PC_RST = 15'h0000;
    localparam instr_t INSTR_RST = 14'h0000;

    // =========================================================================
    // Instruction encodings
    localparam logic [5:0] OPC_AND_LIT = 6'h39;
    localparam logic [5:0] OPC_AND_FILE = 6'h05;
    localparam logic [5:0] OPC_ASR = 6'h37;
    localparam logic [3:0] OPC_BIT_CLEAR = 4'h4;
    localparam logic [3:0] OPC_BIT_SET = 4'h5;
    localparam logic [3:0] OPC_SKIP_CLEAR = 4'h6;
    localparam logic [4:0] OPC_LIT_BRANCH = 5'h19;
    localparam instr_t OPC_ACC_BRANCH = 14'h000B;

    // AXI responses
    localparam resp_t RESP_OKAY = 2'h0;
    localparam resp_t RESP_SLVERR = 2'h2;
    localparam resp_t RESP_DECERR = 2'h3;

    typedef enum logic [0:0] {
        EXEC_IDLE = 1'b0,
        EXEC_NOP = 1'b1
    } exec_state_e;

    typedef struct packed {
        logic and_literal_op;
        logic and_file_op;
        logic arith_shift_right_op;
        logic bit_clear_op;
        logic bit_set_op;
        logic literal_relative_branch_op;
        logic accumulator_relative_branch_op;
        logic skip_if_bit_clear_op;
    } op_s;

endpackage

// >>> tb/axi_lite_master.sv
// ====
// Register bus master standing in for software
module axi_lite_master (
    input wire logic i_clk,
    output logic o_awvalid,
    input wire logic i_awready,
    output exec_pkg::addr_t o_awaddr,
    output logic o_wvalid,
    input wire logic i_wready,
    output exec_pkg::data_t o_wdata,
    output exec_pkg::strb_t o_wstrb,
    input wire logic i_bvalid,
    output logic o_bready,
    output logic o_arvalid,
    input wire logic i_arready,
    output exec_pkg::addr_t o_araddr,
    input wire logic i_rvalid,
    output logic o_rready
);
    timeunit 1ns;
    timeprecision 100ps;
    import exec_pkg::*;

    initial
    begin
        {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
        o_awaddr = 8'h00;
        o_araddr = 8'h00;
        o_wdata = 32'h0;
        o_wstrb = 4'hF;
    end

    // Released lines flip so a stale value is never mistaken for a live one
    task automatic wr(input addr_t a, input data_t d);
        bit aw_ok;
        bit w_ok;
        @(posedge i_clk);
        o_awvalid <= 1'b1;
        o_awaddr <= a;
        o_wvalid <= 1'b1;
        o_wdata <= d;
        o_bready <= 1'b1;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        while (!(aw_ok && w_ok))
        begin
            @(posedge i_clk);
            if (!aw_ok && i_awready)
            begin
                aw_ok = 1'b1;
                o_awvalid <= 1'b0;
                o_awaddr <= ~a;
            end
            if (!w_ok && i_wready)
            begin
                w_ok = 1'b1;
                o_wvalid <= 1'b0;
                o_wdata <= ~d;
            end
        end
        do @(posedge i_clk); while (!i_bvalid);
        o_bready <= 1'b0;
    endtask

    task automatic rd(input addr_t a);
        @(posedge i_clk);
        o_arvalid <= 1'b1;
        o_araddr <= a;
        o_rready <= 1'b1;
        do @(posedge i_clk); while (!i_arready);
        o_arvalid <= 1'b0;
        o_araddr <= ~a;
        do @(posedge i_clk); while (!i_rvalid);
        o_rready <= 1'b0;
    endtask
endmodule // axi_lite_master

// >>> tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import exec_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    addr_t awaddr, araddr;
    data_t wdata, rdata;
    strb_t wstrb;
    resp_t bresp, rresp;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 92;
    data_t qd[$];
    resp_t qr[$], qb[$];
    logic [7:0] acc_m = 8'h00, v, r;
    logic c_m = 1'b0, z_m = 1'b0;
    pc_t pc_m = PC_RST, p;
    logic [6:0] f;
    logic [8:0] k;

    always #2.5 clk = ~clk;

    cpu_and_shift_bit_branch_exec dut (.i_clk(clk), .i_rst(rst),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
        .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp));
    axi_lite_master bus (.i_clk(clk), .o_awvalid(awvalid), .i_awready(awready),
        .o_awaddr(awaddr), .o_wvalid(wvalid), .i_wready(wready), .o_wdata(wdata),
        .o_wstrb(wstrb), .i_bvalid(bvalid), .o_bready(bready), .o_arvalid(arvalid),
        .i_arready(arready), .o_araddr(araddr), .i_rvalid(rvalid), .o_rready(rready));

    // ====
    // Checking
    task automatic cmp_data(input string n, input data_t e, input data_t s);
        cmp_count++;
        if (s !== e)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cmp_resp(input string n, input resp_t e, input resp_t s);
        cmp_count++;
        if (s !== e)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Results are judged at the handshake edge, before the slave drops them
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (rvalid && rready)
        begin
            cmp_data("rdata", qd.pop_front(), rdata);
            cmp_resp("rresp", qr.pop_front(), rresp);
        end
        if (bvalid && bready)
            cmp_resp("bresp", qb.pop_front(), bresp);
        if (cycles == 20000)
        begin
            failures++;
            print_verdict;
        end
    end

    // ====
    // Bus helpers
    function automatic logic [7:0] r8();
        return 8'($random(seed));
    endfunction
    task automatic wr(input addr_t a, input data_t d, input resp_t e = RESP_OKAY);
        qb.push_back(e);
        bus.wr(a, d);
    endtask
    task automatic rd(input addr_t a, input data_t e, input resp_t s = RESP_OKAY);
        qd.push_back(e);
        qr.push_back(s);
        bus.rd(a);
    endtask
    task automatic ex(input instr_t i);
        wr(OFS_INSTR, {18'h0, i});
        pc_m = pc_m + 15'd1;
    endtask
    task automatic setup(input logic [7:0] a);
        logic [7:0] s;
        s = r8();
        acc_m = a;
        c_m = s[0];
        z_m = s[1];
        wr(OFS_ACC, {24'h0, a});
        wr(OFS_STATUS, {30'h0, s[1:0]});
    endtask
    task automatic fset(input logic [6:0] a, input logic [7:0] d);
        wr(OFS_FSEL, {25'h0, a});
        wr(OFS_FDATA, {24'h0, d});
    endtask
    task automatic fchk(input logic [6:0] a, input logic [7:0] e);
        wr(OFS_FSEL, {25'h0, a});
        rd(OFS_FDATA, {24'h0, e});
    endtask
    task automatic core_chk;
        rd(OFS_ACC, {24'h0, acc_m});
        rd(OFS_STATUS, {30'h0, z_m, c_m});
        rd(OFS_PC, {17'h0, pc_m});
    endtask

    // ====
    // Scenarios
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_INSTR, 32'h0);
        rd(OFS_FSEL, 32'h0);
        core_chk;
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            setup(r8());
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : r8();
            ex({OPC_AND_LIT, v});
            acc_m = acc_m & v;
            z_m = (acc_m == 8'h00);
            core_chk;
        end
        $display("test and_literal done");
        for (int i = 0; i < 8; i++)
        begin
            f = 7'(r8());
            v = (i == 4) ? 8'h81 : (i == 5) ? 8'h01 : (i == 3) ? 8'h00 : r8();
            fset(f, v);
            setup(r8());
            ex({i[2] ? OPC_ASR : OPC_AND_FILE, i[0], f});
            r = i[2] ? {v[7], v[7:1]} : (acc_m & v);
            if (i[2])
                c_m = v[0];
            z_m = (r == 8'h00);
            if (i[0])
                v = r;
            else
                acc_m = r;
            fchk(f, v);
            core_chk;
        end
        $display("test and_file shift done");
        for (int i = 0; i < 24; i++)
        begin
            f = 7'(r8());
            v = r8();
            v[i[2:0]] = i[0];
            fset(f, v);
            setup(r8());
            ex({(i < 8) ? OPC_BIT_CLEAR : (i < 16) ? OPC_BIT_SET : OPC_SKIP_CLEAR, i[2:0], f});
            if (i < 8)
                v[i[2:0]] = 1'b0;
            else if (i < 16)
                v[i[2:0]] = 1'b1;
            else if (!v[i[2:0]])
                pc_m = pc_m + 15'd1;
            fchk(f, v);
            core_chk;
        end
        $display("test bit ops skip done");
        for (int i = 0; i < 4; i++)
        begin
            p = (i == 0) ? 15'h0000 : (i == 1) ? 15'h7FF0 : {r8(), 7'(r8())};
            k = (i == 0) ? 9'h100 : (i == 1) ? 9'h0FF : 9'($random(seed));
            setup((i == 1) ? 8'hFF : r8());
            wr(OFS_PC, {17'h0, p});
            pc_m = p;
            ex(OPC_ACC_BRANCH);
            pc_m = pc_m + {7'h0, acc_m};
            core_chk;
            ex({OPC_LIT_BRANCH, k});
            pc_m = pc_m + {{6{k[8]}}, k};
            core_chk;
        end
        rd(OFS_INSTR, {18'h0, OPC_LIT_BRANCH, k});
        // The read is timed to be taken in the no-op cycle, so busy must show
        fork
            ex(OPC_ACC_BRANCH);
            begin
                repeat (2) @(posedge clk);
                rd(OFS_STATUS, {23'h0, 1'b1, 6'h0, z_m, c_m});
            end
        join
        pc_m = pc_m + {7'h0, acc_m};
        core_chk;
        // Codes outside the subset step the counter and load the instruction register, touching nothing else
        ex(14'h0000);
        core_chk;
        $display("test branches done");
        // Busy is read only, so the write leaves it clear
        wr(OFS_STATUS, 32'h0000_0103);
        rd(OFS_STATUS, 32'h0000_0003);
        wr(8'h18, {r8(), r8(), r8(), r8()}, RESP_DECERR);
        rd(8'hFC, 32'h0, RESP_DECERR);
        $display("test register bus done");
        @(posedge clk);
        print_verdict;
    end
endmodule // testbench
